// ---- verilog/dram_access_port.sv ----
`timescale 1ns/1ps
module dram_access_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_master_clock_pos,
    input wire logic i_master_clock_neg,
    input wire logic [11:0] i_command_bus,
    input wire logic [15:0] i_data_pairs_true,
    input wire logic [15:0] i_data_pairs_comp,
    input wire logic [1:0] i_width_sel,
    input wire logic i_serial_in,
    output logic [15:0] o_data_pairs_true,
    output logic [15:0] o_data_pairs_comp,
    output logic [15:0] o_data_oe,
    output logic o_serial_out,
    output logic [7:0] o_bank_open
);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // unknown width code falls back to full width
    function automatic logic [15:0] lane_mask(input logic [1:0] sel);
        case (sel)
            xport_pkg::WIDTH_X8: lane_mask = xport_pkg::MASK_X8;
            xport_pkg::WIDTH_X4: lane_mask = xport_pkg::MASK_X4;
            default: lane_mask = xport_pkg::MASK_X16;
        endcase
    endfunction

    function automatic logic [8:0] sense_idx(input logic [2:0] bank,
                                             input logic [5:0] col);
        sense_idx = {bank, col};
    endfunction

    function automatic logic [12:0] store_idx(input logic [2:0] bank,
                                              input logic [3:0] row,
                                              input logic [5:0] col);
        store_idx = {bank, row, col};
    endfunction

    // -----------------------------------------------------------------
    // link side synchronisers
    // -----------------------------------------------------------------
    logic lrst_meta;
    logic lrst_n;
    logic [1:0] wsel_meta;
    logic [1:0] wsel;
    logic ack_meta;
    logic ack_sync;
    logic ack_tog;

    // reset, width select and acknowledge enter the link domain
    always_ff @(posedge i_master_clock_pos) begin
        lrst_meta <= i_rst_n;
        lrst_n <= lrst_meta;
        wsel_meta <= i_width_sel;
        wsel <= wsel_meta;
        ack_meta <= ack_tog;
        ack_sync <= ack_meta;
    end

    // -----------------------------------------------------------------
    // link logic, on the interface clock
    // -----------------------------------------------------------------
    logic [2:0] ph;
    logic [11:0] word0;
    logic [5:0] wcnt;
    logic [5:0] rcnt;
    logic [255:0] wshift;
    logic [15:0] out_true;
    logic [15:0] out_comp;
    logic [15:0] out_oe;
    logic req_tog;
    xport_pkg::req_kind_t req_kind;
    logic [2:0] req_bank;
    logic [3:0] req_row;
    logic [5:0] req_col;
    logic [2:0] wr_bank;
    logic [5:0] wr_col;
    logic [255:0] rdata;

    logic [2:0] next_ph;
    logic [11:0] next_word0;
    logic [5:0] next_wcnt;
    logic [5:0] next_rcnt;
    logic [255:0] next_wshift;
    logic [15:0] next_out_true;
    logic [15:0] next_out_comp;
    logic [15:0] next_out_oe;
    logic next_req_tog;
    xport_pkg::req_kind_t next_req_kind;
    logic [2:0] next_req_bank;
    logic [3:0] next_req_row;
    logic [5:0] next_req_col;
    logic [2:0] next_wr_bank;
    logic [5:0] next_wr_col;

    // packets start at window 0; writes finish at window 7, so a
    // data-end request never meets a packet decode on the same edge
    always_comb begin
        logic [11:0] cmd_word;
        logic [15:0] mask;
        logic [3:0] op;
        logic [2:0] bank;
        logic busy;
        logic [5:0] widx;
        cmd_word = ~i_command_bus;
        mask = lane_mask(wsel);
        op = word0[xport_pkg::OP_MSB:xport_pkg::OP_LSB];
        bank = word0[xport_pkg::BANK_MSB:xport_pkg::BANK_LSB];
        busy = req_tog != ack_sync;
        widx = xport_pkg::WIN_LAST - rcnt;
        next_ph = ph + xport_pkg::PH_STEP;
        next_word0 = word0;
        next_wcnt = wcnt;
        next_rcnt = rcnt;
        next_wshift = wshift;
        next_out_true = out_true;
        next_out_comp = out_comp;
        next_out_oe = '0;
        next_req_tog = req_tog;
        next_req_kind = req_kind;
        next_req_bank = req_bank;
        next_req_row = req_row;
        next_req_col = req_col;
        next_wr_bank = wr_bank;
        next_wr_col = wr_col;
        // first command word is held for a whole cycle
        if (ph == xport_pkg::PH_WORD0) begin
            next_word0 = cmd_word;
        end
        // write packet: sixteen windows, first word lands lowest; one
        // column access in flight, a new column command restarts counts
        if (wcnt != '0) begin
            next_wcnt = wcnt - xport_pkg::WIN_ONE;
            if (wcnt <= xport_pkg::WIN_LAST) begin
                next_wshift = {i_data_pairs_true & mask,
                               wshift[255:16]};
            end
            if (wcnt == xport_pkg::WIN_ONE && !busy) begin
                next_req_tog = ~req_tog;
                next_req_kind = xport_pkg::REQ_WR;
                next_req_bank = wr_bank;
                next_req_col = wr_col;
            end
        end
        // read packet: one word per window on enabled lanes only
        if (rcnt != '0) begin
            next_rcnt = rcnt - xport_pkg::WIN_ONE;
            if (rcnt <= xport_pkg::WIN_LAST) begin
                next_out_true = rdata[{widx[3:0], 4'h0} +: 16] & mask;
                next_out_comp = ~next_out_true;
                next_out_oe = mask;
            end
        end
        // second word completes the packet
        if (ph == xport_pkg::PH_WORD1 && op != xport_pkg::OP_NOP) begin
            case (op)
                xport_pkg::OP_ACTIVATE: begin
                    if (!busy) begin
                        next_req_tog = ~req_tog;
                        next_req_kind = xport_pkg::REQ_ACT;
                        next_req_bank = bank;
                        next_req_row = cmd_word[3:0];
                    end
                end
                xport_pkg::OP_PRECHARGE: begin
                    if (!busy) begin
                        next_req_tog = ~req_tog;
                        next_req_kind = xport_pkg::REQ_PRE;
                        next_req_bank = bank;
                    end
                end
                xport_pkg::OP_WRITE: begin
                    next_wcnt = xport_pkg::WR_LOAD;
                    next_wr_bank = bank;
                    next_wr_col = cmd_word[5:0];
                end
                xport_pkg::OP_READ: begin
                    next_rcnt = xport_pkg::RD_LOAD;
                    if (!busy) begin
                        next_req_tog = ~req_tog;
                        next_req_kind = xport_pkg::REQ_RD;
                        next_req_bank = bank;
                        next_req_col = cmd_word[5:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // link registers; pairs idle (not driven) in and after reset
    always_ff @(posedge i_master_clock_pos) begin
        if (!lrst_n) begin
            ph <= xport_pkg::PH_WORD0;
            word0 <= '0;
            wcnt <= '0;
            rcnt <= '0;
            wshift <= '0;
            out_true <= '0;
            out_comp <= '1;
            out_oe <= '0;
            req_tog <= 1'b0;
            req_kind <= xport_pkg::REQ_ACT;
            req_bank <= '0;
            req_row <= '0;
            req_col <= '0;
            wr_bank <= '0;
            wr_col <= '0;
        end else begin
            ph <= next_ph;
            word0 <= next_word0;
            wcnt <= next_wcnt;
            rcnt <= next_rcnt;
            wshift <= next_wshift;
            out_true <= next_out_true;
            out_comp <= next_out_comp;
            out_oe <= next_out_oe;
            req_tog <= next_req_tog;
            req_kind <= next_req_kind;
            req_bank <= next_req_bank;
            req_row <= next_req_row;
            req_col <= next_req_col;
            wr_bank <= next_wr_bank;
            wr_col <= next_wr_col;
        end
    end

    assign o_data_pairs_true = out_true;
    assign o_data_pairs_comp = out_comp;
    assign o_data_oe = out_oe;

    // -----------------------------------------------------------------
    // core side, on the system clock
    // -----------------------------------------------------------------
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic ser_meta;
    logic ser_sync;
    logic req_edge;
    logic [7:0] open_bits;
    logic [7:0][3:0] open_row;
    logic next_ack_tog;
    logic [255:0] next_rdata;
    logic [7:0] next_open_bits;
    logic [7:0][3:0] next_open_row;
    logic [255:0] sense [xport_pkg::SENSE_DEPTH];
    logic [255:0] store [xport_pkg::STORE_DEPTH];

    // request toggle crosses in; serial input is synchronised and reaches the output three clocks later
    always_ff @(posedge i_clk) begin
        req_meta <= req_tog;
        req_sync <= req_meta;
        ser_meta <= i_serial_in;
        ser_sync <= ser_meta;
        if (!i_rst_n) begin
            req_seen <= 1'b0;
            o_serial_out <= 1'b1;
        end else begin
            req_seen <= req_sync;
            o_serial_out <= ser_sync;
        end
    end

    // request fields are stable here: the link holds them until acked
    assign req_edge = req_sync ^ req_seen;

    always_comb begin
        next_ack_tog = ack_tog;
        next_rdata = rdata;
        next_open_bits = open_bits;
        next_open_row = open_row;
        if (req_edge) begin
            next_ack_tog = ~ack_tog;
            unique case (req_kind)
                xport_pkg::REQ_ACT: begin
                    next_open_bits[req_bank] = 1'b1;
                    next_open_row[req_bank] = req_row;
                end
                xport_pkg::REQ_PRE: begin
                    next_open_bits[req_bank] = 1'b0;
                end
                xport_pkg::REQ_RD: begin
                    if (open_bits[req_bank]) begin
                        next_rdata = sense[sense_idx(req_bank,
                                                     req_col)];
                    end
                end
                xport_pkg::REQ_WR: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_tog <= 1'b0;
            rdata <= '0;
            open_bits <= '0;
            open_row <= '0;
        end else begin
            ack_tog <= next_ack_tog;
            rdata <= next_rdata;
            open_bits <= next_open_bits;
            open_row <= next_open_row;
        end
    end

    // core arrays; a precharge of a closed bank writes nothing back
    always_ff @(posedge i_clk) begin
        if (req_edge) begin
            for (int c = 0; c < xport_pkg::NUM_COLS; c++) begin
                if (req_kind == xport_pkg::REQ_ACT) begin
                    sense[sense_idx(req_bank, c[5:0])] <=
                        store[store_idx(req_bank, req_row, c[5:0])];
                end
                if (req_kind == xport_pkg::REQ_PRE && open_bits[req_bank])
                begin
                    store[store_idx(req_bank, open_row[req_bank],
                                    c[5:0])] <=
                        sense[sense_idx(req_bank, c[5:0])];
                end
            end
            if (req_kind == xport_pkg::REQ_WR && open_bits[req_bank]) begin
                sense[sense_idx(req_bank, req_col)] <= wshift;
            end
        end
    end

    assign o_bank_open = open_bits;

endmodule // dram_access_port

// ---- verilog/xport_pkg.sv ----
package xport_pkg;
    // -----------------------------------------------------------------
    // geometry
    // -----------------------------------------------------------------
    localparam int NUM_BANKS = 8;
    localparam int BANK_BITS = 3;
    localparam int ROW_BITS = 4;
    localparam int COL_BITS = 6;
    localparam int NUM_COLS = 64;
    localparam int LANES = 16;
    localparam int PACKET_WORDS = 16;
    localparam int PACKET_BITS = 256;
    localparam int CMD_WIDTH = 12;
    localparam int SENSE_DEPTH = 512;
    localparam int STORE_DEPTH = 8192;

    // -----------------------------------------------------------------
    // bit windows: eight per interface clock cycle
    // -----------------------------------------------------------------
    localparam int PHASES = 8;
    localparam logic [2:0] PH_STEP = 3'h1;
    localparam logic [2:0] PH_WORD0 = 3'h0;
    localparam logic [2:0] PH_WORD1 = 3'h4;

    // -----------------------------------------------------------------
    // command packet fields (logic values after inversion)
    // -----------------------------------------------------------------
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int BANK_MSB = 7;
    localparam int BANK_LSB = 5;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ACTIVATE = 4'h1;
    localparam logic [3:0] OP_READ = 4'h2;
    localparam logic [3:0] OP_WRITE = 4'h3;
    localparam logic [3:0] OP_PRECHARGE = 4'h4;

    // -----------------------------------------------------------------
    // data width select and lane masks
    // -----------------------------------------------------------------
    localparam logic [1:0] WIDTH_X16 = 2'h0;
    localparam logic [1:0] WIDTH_X8 = 2'h1;
    localparam logic [1:0] WIDTH_X4 = 2'h2;
    localparam logic [15:0] MASK_X16 = 16'hffff;
    localparam logic [15:0] MASK_X8 = 16'h00ff;
    localparam logic [15:0] MASK_X4 = 16'h000f;

    // -----------------------------------------------------------------
    // timing, in interface clock cycles, and window counter loads
    // -----------------------------------------------------------------
    localparam int WRITE_DATA_DELAY_CYC = 3;
    localparam int COLUMN_ACCESS_LATENCY_CYC = 6;
    localparam int COLUMN_CYCLE_TIME_CYC = 2;
    localparam int WIN_BITS = 6;
    localparam logic [5:0] WIN_ONE = 6'h01;
    localparam logic [5:0] WIN_LAST = 6'h10;
    localparam logic [5:0] WR_LOAD = 6'(WRITE_DATA_DELAY_CYC * PHASES
        - int'(PH_WORD1) + PACKET_WORDS - 1);
    localparam logic [5:0] RD_LOAD = 6'(COLUMN_ACCESS_LATENCY_CYC * PHASES
        - int'(PH_WORD1) + PACKET_WORDS - 1);

    typedef enum logic [1:0] {
        REQ_ACT,
        REQ_PRE,
        REQ_WR,
        REQ_RD
    } req_kind_t;
endpackage

// ---- bench/dram_access_port_props.sv ----
`timescale 1ns/1ps
module port_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_master_clock_pos,
    input wire logic [11:0] i_command_bus,
    input wire logic [1:0] i_width_sel,
    input wire logic i_serial_in,
    input wire logic [15:0] o_data_pairs_true,
    input wire logic [15:0] o_data_pairs_comp,
    input wire logic [15:0] o_data_oe,
    input wire logic o_serial_out,
    input wire logic [7:0] o_bank_open
);
    // ------------------------------------------
    // decode and burst tracking
    // ------------------------------------------
    logic [3:0] op;
    logic [15:0] mask;
    logic busy;
    logic [4:0] run;
    logic [4:0] next_run;
    logic [2:0] bank;
    logic [2:0] next_bank;
    // command pins are low-true, so invert before decoding
    assign op = ~i_command_bus[11:8];
    assign busy = |o_data_oe;
    assign mask = (i_width_sel == xport_pkg::WIDTH_X8) ? xport_pkg::MASK_X8
        : (i_width_sel == xport_pkg::WIDTH_X4) ? xport_pkg::MASK_X4
        : xport_pkg::MASK_X16;
    // only the low four bits of run matter: bursts may run back to back
    always_comb begin
        next_run = (busy && i_rst_n) ? run + 5'h01 : 5'h00;
        next_bank = (op != xport_pkg::OP_NOP) ? ~i_command_bus[7:5] : bank;
    end
    always_ff @(posedge i_master_clock_pos) begin
        run <= next_run;
        bank <= next_bank;
    end
    // ------------------------------------------
    // assertions
    // ------------------------------------------
    a_comp_inverse:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        o_data_pairs_comp == ~o_data_pairs_true)
        else $error("complement lines not the inverse of true lines");
    a_lane_enable:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        busy |-> (o_data_oe & ~mask) == 16'h0000)
        else $error("disabled lane driven");
    a_lane_zero:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        busy |-> (o_data_pairs_true & ~mask) == 16'h0000)
        else $error("unused lane not zero");
    a_burst_len:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        $fell(busy) |-> run[3:0] == 4'h0)
        else $error("read burst not a multiple of sixteen windows");
    a_read_latency:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        $rose(op == xport_pkg::OP_READ) |-> ##49 busy)
        else $error("read data not driven after access latency");
    a_bank_opens:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        $rose(op == xport_pkg::OP_ACTIVATE) |-> ##[1:24] o_bank_open[bank])
        else $error("activated bank not open");
    a_bank_closes:
    assert property (@(posedge i_master_clock_pos) disable iff (!i_rst_n)
        $rose(op == xport_pkg::OP_PRECHARGE) |-> ##[1:24] !o_bank_open[bank])
        else $error("precharged bank still open");
    a_serial_delay:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_serial_out == $past(i_serial_in, 3))
        else $error("serial output not three cycles behind input");
    a_reset_state:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> o_bank_open == 8'h00 && o_serial_out)
        else $error("wrong state after reset");
endmodule // port_checker

bind dram_access_port port_checker u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_master_clock_pos(i_master_clock_pos), .i_command_bus(i_command_bus),
    .i_width_sel(i_width_sel), .i_serial_in(i_serial_in),
    .o_data_pairs_true(o_data_pairs_true),
    .o_data_pairs_comp(o_data_pairs_comp),
    .o_data_oe(o_data_oe), .o_serial_out(o_serial_out),
    .o_bank_open(o_bank_open));

// ---- bench/link_controller_model.sv ----
`timescale 1ns/1ps
module link_controller_model (
    input wire logic i_rst_n,
    input wire logic [15:0] i_rd_true,
    output logic o_clk_pos,
    output logic o_clk_neg,
    output logic [11:0] o_cmd,
    output logic [15:0] o_wr_true,
    output logic [15:0] o_wr_comp
);
    logic [1:0] sync = 2'h0;
    int g = 0;
    int d;
    int e;
    logic [255:0] wr_q[$];
    int wr_at[$];
    int rd_at[$];
    logic [255:0] rd_buf;
    logic [255:0] rd_done[$];
    // free-running link clock, phase unrelated to the core clock
    initial begin
        o_clk_pos = 1'b0;
        o_cmd = 12'hfff;
        o_wr_true = 16'h0000;
        #13;
        forever #32 o_clk_pos = ~o_clk_pos;
    end
    assign o_clk_neg = ~o_clk_pos;
    assign o_wr_comp = ~o_wr_true;
    // window count since the port left reset; g is 0 mod 8 just before
    // a phase 0 edge, since g reads n+1 after link edge n
    always @(posedge o_clk_pos) begin
        sync <= {sync[0], i_rst_n};
        g <= sync[1] ? g + 1 : 0;
        d = (wr_at.size() > 0) ? g - 22 - wr_at[0] : -1;
        if (d >= 0 && d < 16) begin
            o_wr_true <= wr_q[0][16*d +: 16];
            if (d == 15) begin
                void'(wr_q.pop_front());
                void'(wr_at.pop_front());
            end
        end else begin
            o_wr_true <= ~o_wr_true; // released: toggles, never a stale copy
        end
    end
    // read windows are sampled mid-period, clear of the launching edge
    always @(negedge o_clk_pos) begin
        e = (rd_at.size() > 0) ? g - 48 - rd_at[0] : -1;
        if (e >= 0 && e < 16) begin
            rd_buf[16*e +: 16] = i_rd_true;
        end
        if (e == 15) begin
            rd_done.push_back(rd_buf);
            void'(rd_at.pop_front());
        end
    end
    // one request: word0 at phase 0, word1 at phase 4, one window each
    task automatic cmd(input logic [3:0] op, input logic [2:0] bank,
            input logic [11:0] arg, input logic [255:0] data);
        do begin
            @(posedge o_clk_pos);
            #1;
        end while (g % 8 != 0);
        o_cmd = ~{op, bank, 5'h00};
        if (op == xport_pkg::OP_WRITE) begin
            wr_at.push_back(g + 1);
            wr_q.push_back(data);
        end
        if (op == xport_pkg::OP_READ) begin
            rd_at.push_back(g + 1);
        end
        @(posedge o_clk_pos);
        #1;
        o_cmd = 12'hfff;
        repeat (3) @(posedge o_clk_pos);
        #1;
        o_cmd = ~arg;
        @(posedge o_clk_pos);
        #1;
        o_cmd = 12'hfff;
    endtask
    task automatic idle(input int n);
        repeat (8 * n) @(posedge o_clk_pos);
    endtask
    task automatic take_read(output logic [255:0] data);
        int n = 0;
        while (rd_done.size() == 0 && n < 300) begin
            @(posedge o_clk_pos);
            n++;
        end
        data = (rd_done.size() > 0) ? rd_done.pop_front() : 'x;
    endtask
endmodule // link_controller_model

// ---- bench/tb_dram_access_port.sv ----
`timescale 1ns/1ps
module tb_dram_access_port;
    logic i_clk;
    logic i_rst_n;
    logic [1:0] width;
    logic ser_in;
    logic lk_pos, lk_neg, ser_out;
    logic [11:0] cmd_bus;
    logic [15:0] wt, wc, rt, rc, oe;
    logic [7:0] bank_open;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // ------------------------------------------
    // clock, instances, reporting
    // ------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    dram_access_port uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_master_clock_pos(lk_pos), .i_master_clock_neg(lk_neg),
        .i_command_bus(cmd_bus), .i_data_pairs_true(wt),
        .i_data_pairs_comp(wc), .i_width_sel(width), .i_serial_in(ser_in),
        .o_data_pairs_true(rt), .o_data_pairs_comp(rc), .o_data_oe(oe),
        .o_serial_out(ser_out), .o_bank_open(bank_open));
    link_controller_model u_ctl (.i_rst_n(i_rst_n), .i_rd_true(rt),
        .o_clk_pos(lk_pos), .o_clk_neg(lk_neg), .o_cmd(cmd_bus),
        .o_wr_true(wt), .o_wr_comp(wc));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_flag(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pkt(input logic [255:0] got, input logic [255:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the whole run should take a few thousand cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    // distinct words so a swapped or repeated window shows up
    function automatic logic [255:0] pat(input logic [7:0] s,
            input logic [15:0] m);
        for (int n = 0; n < 16; n++) begin
            pat[16*n +: 16] = {s, 8'(n * 17)} & m;
        end
    endfunction
    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic s_serial;
        logic [7:0] bits = 8'h96;
        cmp_flag({8'h00, bank_open}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            ser_in <= bits[i];
            repeat (3) @(posedge i_clk);
            #1;
            cmp_flag({15'h0000, ser_out}, {15'h0000, bits[i]});
        end
        @(posedge i_clk);
        ser_in <= 1'b1;
    endtask
    // narrow widths keep only the low lanes; boundary column 63 included
    task automatic s_access(input logic [1:0] w, input logic [15:0] m,
            input logic [2:0] b);
        logic [255:0] got;
        @(posedge i_clk);
        width <= w;
        u_ctl.idle(2);
        u_ctl.cmd(xport_pkg::OP_ACTIVATE, b, 12'h005, '0);
        u_ctl.idle(2);
        // one column access in flight: let each packet end before the next
        u_ctl.cmd(xport_pkg::OP_WRITE, b, 12'h007, pat(8'ha0, 16'hffff));
        u_ctl.idle(4);
        u_ctl.cmd(xport_pkg::OP_WRITE, b, 12'h03f, pat(8'hc3, 16'hffff));
        u_ctl.idle(6);
        u_ctl.cmd(xport_pkg::OP_READ, b, 12'h007, '0);
        u_ctl.idle(7);
        u_ctl.cmd(xport_pkg::OP_READ, b, 12'h03f, '0);
        u_ctl.take_read(got);
        cmp_pkt(got, pat(8'ha0, m));
        u_ctl.take_read(got);
        cmp_pkt(got, pat(8'hc3, m));
        @(posedge lk_pos);
        #1;
        cmp_flag(oe, 16'h0000);
        cmp_flag({8'h00, bank_open}, {8'h00, 8'h01 << b});
        u_ctl.cmd(xport_pkg::OP_PRECHARGE, b, 12'h000, '0);
        u_ctl.idle(3);
        cmp_flag({8'h00, bank_open}, 16'h0000);
        u_ctl.cmd(xport_pkg::OP_ACTIVATE, b, 12'h005, '0);
        u_ctl.idle(2);
        u_ctl.cmd(xport_pkg::OP_READ, b, 12'h007, '0);
        u_ctl.take_read(got);
        cmp_pkt(got, pat(8'ha0, m));
        u_ctl.cmd(xport_pkg::OP_PRECHARGE, b, 12'h000, '0);
        u_ctl.idle(3);
    endtask
    task automatic s_banks;
        for (int b = 0; b < 8; b++) begin
            u_ctl.cmd(xport_pkg::OP_ACTIVATE, 3'(b), 12'(b), '0);
            u_ctl.idle(2);
        end
        cmp_flag({8'h00, bank_open}, 16'h00ff);
        for (int b = 0; b < 8; b++) begin
            u_ctl.cmd(xport_pkg::OP_PRECHARGE, 3'(b), 12'h000, '0);
            u_ctl.idle(2);
        end
        cmp_flag({8'h00, bank_open}, 16'h0000);
    endtask
    initial begin
        i_rst_n <= 1'b0;
        width <= xport_pkg::WIDTH_X16;
        ser_in <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        s_serial();
        s_access(xport_pkg::WIDTH_X16, xport_pkg::MASK_X16, 3'h2);
        s_access(xport_pkg::WIDTH_X8, xport_pkg::MASK_X8, 3'h5);
        s_access(xport_pkg::WIDTH_X4, xport_pkg::MASK_X4, 3'h7);
        s_banks();
        complete_run();
    end
endmodule // tb_dram_access_port
